// ===== verilog/bmr_pkg.sv
`default_nettype none
package bmr_pkg;
    localparam int BMR_NV_BITS = 4;
    localparam int BMR_MASTERS = 2;
    localparam logic [1:0] BMR_BOOT_NV_IDX = 2'h3;
    localparam logic [3:0] BMR_NV_RESET = 4'h0;
    localparam logic [31:0] BMR_ZERO_BASE = 32'h0000_0000;
    localparam logic [31:0] BMR_ZERO_LAST = 32'h0fff_ffff;
    localparam logic [3:0] BMR_ZERO_PAGE = 4'h0;
    localparam logic [3:0] BMR_ROM_PAGE = 4'h1;
    localparam logic [3:0] BMR_FLASH_PAGE = 4'h2;
    localparam logic [3:0] BMR_SRAM_PAGE = 4'h3;
    localparam logic [31:0] BMR_OFFSET_MASK = 32'h0fff_ffff;
    localparam logic BMR_REMAP_RESET = 1'b0;
    localparam logic BMR_BOOT_RESET = 1'b0;

    typedef enum logic [1:0] {
        BMR_TGT_NONE = 2'b00,
        BMR_TGT_ROM = 2'b01,
        BMR_TGT_FLASH = 2'b10,
        BMR_TGT_SRAM = 2'b11
    } bmr_tgt_t;

    typedef enum logic {
        BMR_CAP_WAIT = 1'b0,
        BMR_CAP_DONE = 1'b1
    } bmr_cap_t;

    function automatic bmr_tgt_t bmr_target(input logic [31:0] addr, input logic remap, input logic boot);
        bmr_tgt_t t;
        t = BMR_TGT_NONE;
        case (addr[31:28])
            BMR_ZERO_PAGE: t = remap ? BMR_TGT_SRAM : (boot ? BMR_TGT_FLASH : BMR_TGT_ROM);
            BMR_ROM_PAGE: t = BMR_TGT_ROM;
            BMR_FLASH_PAGE: t = BMR_TGT_FLASH;
            BMR_SRAM_PAGE: t = BMR_TGT_SRAM;
            default: t = BMR_TGT_NONE;
        endcase
        return t;
    endfunction : bmr_target
endpackage : bmr_pkg
`default_nettype wire

// ===== verilog/bmr_nv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bmr_nv_if;
    logic set;
    logic clr;
    logic erase;
    logic [1:0] idx;
    logic [3:0] bits;
    modport ctrl (output set, output clr, output erase, output idx, input bits);
    modport store (input set, input clr, input erase, input idx, output bits);
endinterface : bmr_nv_if
`default_nettype wire

// ===== verilog/bmr_nv_store.sv
`timescale 1ns/1ps
`default_nettype none
module bmr_nv_store
    import bmr_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_por_n,
    bmr_nv_if.store nv
);
    // only power-on and a full erase clear these; system resets leave them alone, as a
    // stand-in for cells that keep their value without supply
    logic [3:0] bits_q;
    logic [3:0] bits_d;
    logic [3:0] idx_onehot;

    assign idx_onehot = 4'h1 << nv.idx;
    assign bits_d = nv.erase ? BMR_NV_RESET :
                    nv.set ? (bits_q | idx_onehot) :
                    nv.clr ? (bits_q & ~idx_onehot) : bits_q; // [R7] [R11]
    assign nv.bits = bits_q;

    always_ff @(posedge i_sys_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            bits_q <= BMR_NV_RESET;
        end else begin
            bits_q <= bits_d; // [R11]
        end
    end

    a_erase_clears: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R7]
        nv.erase |=> (bits_q == BMR_NV_RESET))
        else $error("full erase left a nv bit set");
    a_set_sticks: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R11]
        (nv.set && !nv.erase) |=> bits_q[$past(nv.idx)])
        else $error("nv set command not applied");
endmodule : bmr_nv_store
`default_nettype wire

// ===== verilog/bmr_decoder.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] A valid memory is always decoded at address zero, so fetch after any reset lands somewhere real.
// [R2] With the sram-at-zero select on, the zero region goes to the first SRAM bank whatever the boot bit says.
// [R3] With the select off and the captured boot bit set, the zero region goes to the Flash.
// [R4] With the select off and the captured boot bit clear, the zero region goes to the ROM, clear being the Flash reset state.
// [R5] The ROM/Flash choice uses the boot bit as caught at reset, not its live value afterwards.
// [R6] The whole range from zero to 0x0FFF_FFFF is given to the boot alias.
// [R7] A full Flash erase clears the boot bit, so the next boot without remap uses the ROM.
// [R8] Every memory stays reachable at its own fixed base; only the zero alias moves.
// [R9] Software turns the sram-at-zero select on only once booting from the initial memory is over.
// [R10] The sram-at-zero select is off after reset and keeps its value until software changes it or reset returns.
// [R11] The boot bit is bit 3 of four nv bits, set and cleared by Flash commands and kept across system resets.
module bmr_decoder
    import bmr_pkg::*;
#(
    parameter int MASTERS = BMR_MASTERS
) (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_por_n,
    input wire logic i_remap_set,
    input wire logic i_remap_clr,
    input wire logic i_nv_set,
    input wire logic i_nv_clr,
    input wire logic [1:0] i_nv_idx,
    input wire logic i_full_erase,
    input wire logic [MASTERS-1:0] i_m_valid,
    input wire logic [MASTERS-1:0][31:0] i_m_addr,
    output logic [MASTERS-1:0] o_m_valid,
    output logic [MASTERS-1:0][1:0] o_m_target,
    output logic [MASTERS-1:0][31:0] o_m_offset,
    output logic o_sram_at_zero_select,
    output logic o_boot_source_select,
    output logic [3:0] o_nv_bits
);
    bmr_nv_if nv ();

    logic remap_q;
    logic remap_d;
    logic boot_q;
    logic boot_d;
    bmr_cap_t cap_q;
    bmr_cap_t cap_d;
    logic boot_live;
    logic boot_eff;

    assign nv.set = i_nv_set;
    assign nv.clr = i_nv_clr;
    assign nv.erase = i_full_erase;
    assign nv.idx = i_nv_idx;

    bmr_nv_store u_nv (
        .i_sys_clk(i_sys_clk),
        .i_por_n(i_por_n),
        .nv(nv)
    );

    assign boot_live = nv.bits[BMR_BOOT_NV_IDX]; // [R11]
    // the first edge after release already sees the live bit, later edges the frozen copy
    assign boot_eff = (cap_q == BMR_CAP_DONE) ? boot_q : boot_live; // [R5]
    assign cap_d = BMR_CAP_DONE;
    assign boot_d = (cap_q == BMR_CAP_WAIT) ? boot_live : boot_q; // [R5]
    // set wins over a clear in the same cycle
    assign remap_d = i_remap_set ? 1'b1 : (i_remap_clr ? 1'b0 : remap_q); // [R10]

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            remap_q <= BMR_REMAP_RESET; // [R10]
            boot_q <= BMR_BOOT_RESET;
            cap_q <= BMR_CAP_WAIT;
        end else begin
            remap_q <= remap_d;
            boot_q <= boot_d;
            cap_q <= cap_d;
        end
    end

    assign o_sram_at_zero_select = remap_q;
    assign o_boot_source_select = boot_q;
    assign o_nv_bits = nv.bits;

    genvar g;
    generate
        for (g = 0; g < MASTERS; g++) begin : g_master
            bmr_tgt_t tgt_d;
            logic [31:0] off_d;
            logic zero_hit;
            // page wires only feed the checks below
            logic [3:0] page;
            logic page_rom;
            logic page_flash;
            logic page_unmapped;

            assign zero_hit = (i_m_addr[g] <= BMR_ZERO_LAST); // [R6]
            assign page = i_m_addr[g][31:28];
            assign page_rom = (page == BMR_ROM_PAGE); // [R8]
            assign page_flash = (page == BMR_FLASH_PAGE); // [R8]
            assign page_unmapped = (page > BMR_SRAM_PAGE); // [R8]
            assign tgt_d = bmr_target(i_m_addr[g], remap_q, boot_eff); // [R1] [R2] [R3] [R4] [R8]
            assign off_d = i_m_addr[g] & BMR_OFFSET_MASK;

            always_ff @(posedge i_sys_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_m_valid[g] <= 1'b0;
                    o_m_target[g] <= BMR_TGT_NONE;
                    o_m_offset[g] <= BMR_ZERO_BASE;
                end else begin
                    o_m_valid[g] <= i_m_valid[g];
                    o_m_target[g] <= tgt_d;
                    o_m_offset[g] <= off_d;
                end
            end

            a_zero_always_mapped: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R1]
                (i_m_valid[g] && zero_hit) |=> (o_m_valid[g] && o_m_target[g] != BMR_TGT_NONE))
                else $error("zero region left unmapped");
            a_remap_to_sram: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R2]
                (i_m_valid[g] && zero_hit && remap_q) |=> (o_m_target[g] == BMR_TGT_SRAM))
                else $error("remap did not send zero region to sram");
            a_boot_flash: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R3]
                (i_m_valid[g] && zero_hit && !remap_q && boot_eff) |=> (o_m_target[g] == BMR_TGT_FLASH))
                else $error("set boot bit did not map flash at zero");
            a_boot_rom: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R4]
                (i_m_valid[g] && zero_hit && !remap_q && !boot_eff) |=> (o_m_target[g] == BMR_TGT_ROM))
                else $error("clear boot bit did not map rom at zero");
            a_full_alias_range: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R6]
                (i_m_valid[g] && zero_hit) |=> (o_m_offset[g] == $past(i_m_addr[g])))
                else $error("zero alias offset wrong");
            a_fixed_bases: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R8]
                (i_m_valid[g] && i_m_addr[g][31:28] == BMR_SRAM_PAGE) |=> (o_m_target[g] == BMR_TGT_SRAM))
                else $error("sram not at its fixed base");

            // the other windows never move either, whatever remap or the boot bit say
            a_rom_fixed_base: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R8]
                (i_m_valid[g] && page_rom) |=> (o_m_target[g] == BMR_TGT_ROM))
                else $error("rom not at its fixed base");
            a_flash_fixed_base: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R8]
                (i_m_valid[g] && page_flash) |=> (o_m_target[g] == BMR_TGT_FLASH))
                else $error("flash not at its fixed base");
            a_unmapped_page: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R8]
                (i_m_valid[g] && page_unmapped) |=> (o_m_target[g] == BMR_TGT_NONE))
                else $error("unmapped page decoded to a memory");
            a_offset_in_window: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R8]
                i_m_valid[g] |=> (o_m_offset[g] == ($past(i_m_addr[g]) & BMR_OFFSET_MASK)))
                else $error("offset inside the window wrong");
            a_valid_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R1]
                1'b1 |=> (o_m_valid[g] == $past(i_m_valid[g])))
                else $error("request strobe not passed on");
            a_sram_over_boot: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R2]
                (i_m_valid[g] && zero_hit && remap_q && boot_eff) |=> (o_m_target[g] == BMR_TGT_SRAM))
                else $error("boot bit overrode the remap select");

            // once captured, a live bit that disagrees must lose
            a_live_set_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R5]
                (i_m_valid[g] && zero_hit && !remap_q && cap_q == BMR_CAP_DONE && !boot_q && boot_live)
                |=> (o_m_target[g] == BMR_TGT_ROM))
                else $error("live boot bit moved zero to flash");
            a_live_clr_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R5]
                (i_m_valid[g] && zero_hit && !remap_q && cap_q == BMR_CAP_DONE && boot_q && !boot_live)
                |=> (o_m_target[g] == BMR_TGT_FLASH))
                else $error("live boot bit moved zero to rom");

            // judged under power-on only, so that system reset itself is what gets checked
            a_reset_quiet_out: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R1]
                !i_rstn |-> (!o_m_valid[g] && o_m_target[g] == BMR_TGT_NONE))
                else $error("outputs not idle in reset");
        end
    endgenerate

    a_boot_frozen: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R5]
        (cap_q == BMR_CAP_DONE) |=> ($stable(boot_q) && boot_eff == boot_q))
        else $error("boot choice followed the live bit");
    a_boot_captured: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R11]
        (cap_q == BMR_CAP_WAIT) |=> (boot_q == $past(nv.bits[3])))
        else $error("boot bit not caught from nv bit 3");
    a_remap_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R10]
        (!i_remap_set && !i_remap_clr) |=> $stable(remap_q))
        else $error("remap select changed on its own");
    a_remap_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R10]
        i_remap_set |=> remap_q)
        else $error("remap set lost");
    a_remap_clr_takes: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R10]
        (i_remap_clr && !i_remap_set) |=> !remap_q)
        else $error("remap clear lost");
    a_cap_once: assert property (@(posedge i_sys_clk) disable iff (!i_rstn) // [R5]
        (cap_q == BMR_CAP_WAIT) |=> (cap_q == BMR_CAP_DONE))
        else $error("boot capture did not close");

    // system reset clears the select and the capture but must never touch the nv bits
    a_remap_reset_off: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R10]
        !i_rstn |-> (remap_q == BMR_REMAP_RESET && cap_q == BMR_CAP_WAIT))
        else $error("remap select not off in reset");
    a_boot_reset_clear: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R5]
        !i_rstn |-> (boot_q == BMR_BOOT_RESET))
        else $error("boot choice not cleared in reset");
    a_nv_kept_reset: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R11]
        (!i_nv_set && !i_nv_clr && !i_full_erase) |=> $stable(nv.bits))
        else $error("nv bits changed without a command");
    a_erase_boot_rom: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R7]
        i_full_erase |=> !nv.bits[BMR_BOOT_NV_IDX])
        else $error("erase left the boot bit set");
    a_nv_clr_applies: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R11]
        (i_nv_clr && !i_nv_set && !i_full_erase) |=> !nv.bits[$past(i_nv_idx)])
        else $error("nv clear command not applied");
    a_other_nv_kept: assert property (@(posedge i_sys_clk) disable iff (!i_por_n) // [R11]
        ((i_nv_set || i_nv_clr) && !i_full_erase) |=> ((nv.bits & ~(4'h1 << $past(i_nv_idx))) ==
            ($past(nv.bits) & ~(4'h1 << $past(i_nv_idx)))))
        else $error("nv command disturbed another bit");


    c_remap_fetch: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
        remap_q && i_m_valid[0] && i_m_addr[0][31:28] == BMR_ZERO_PAGE);
    c_flash_boot: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
        boot_q && !remap_q && i_m_valid[0]);
    c_erase_then_rom: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_full_erase ##1 !nv.bits[3]);
    c_unmapped_page: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
        i_m_valid[0] && i_m_addr[0][31:28] > BMR_SRAM_PAGE);
    c_live_differs: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
        cap_q == BMR_CAP_DONE && boot_q != boot_live && i_m_valid[0]);
endmodule : bmr_decoder
`default_nettype wire

// ===== verif/bmr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmr_master_model (
    input wire logic i_clk,
    output logic [1:0] o_valid,
    output logic [1:0][31:0] o_addr
);
    initial begin
        o_valid = 2'h0;
        o_addr = '0;
    end
    // idle address is inverted so a stale value never looks like a request
    task automatic drive(input logic [1:0] v, input logic [31:0] a0, input logic [31:0] a1);
        @(negedge i_clk);
        o_valid = v;
        o_addr[0] = v[0] ? a0 : ~o_addr[0];
        o_addr[1] = v[1] ? a1 : ~o_addr[1];
    endtask : drive
endmodule : bmr_master_model
`default_nettype wire

// ===== verif/tb_boot_memory_remap_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_boot_memory_remap_decoder;
    import bmr_pkg::*;
    logic i_sys_clk, i_rstn, i_por_n, i_remap_set, i_remap_clr, i_nv_set, i_nv_clr, i_full_erase;
    logic [1:0] i_nv_idx, i_m_valid, o_m_valid;
    logic [1:0][31:0] i_m_addr, o_m_offset;
    logic [1:0][1:0] o_m_target;
    logic o_sram_at_zero_select, o_boot_source_select, remap_m, boot_m;
    logic [3:0] o_nv_bits;
    logic [33:0] expq[$];
    int failures, check_count, cyc;
    bmr_decoder uut (.i_sys_clk, .i_rstn, .i_por_n, .i_remap_set, .i_remap_clr, .i_nv_set, .i_nv_clr,
        .i_nv_idx, .i_full_erase, .i_m_valid, .i_m_addr, .o_m_valid, .o_m_target, .o_m_offset,
        .o_sram_at_zero_select, .o_boot_source_select, .o_nv_bits);
    bmr_master_model mm (.i_clk(i_sys_clk), .o_valid(i_m_valid), .o_addr(i_m_addr));
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    task automatic end_of_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [33:0] ex(input logic [31:0] a);
        logic [1:0] t;
        case (a[31:28])
            4'h0: t = remap_m ? 2'h3 : (boot_m ? 2'h2 : 2'h1);
            4'h1: t = 2'h1;
            4'h2: t = 2'h2;
            4'h3: t = 2'h3;
            default: t = 2'h0;
        endcase
        return {t, a & 32'h0fff_ffff};
    endfunction : ex
    task automatic req(input logic [31:0] a0, input logic [31:0] a1);
        expq.push_back(ex(a0));
        expq.push_back(ex(a1));
        mm.drive(2'h3, a0, a1);
    endtask : req
    // pages 4 and 5 stand for unmapped space
    task automatic burst;
        repeat (6) req({4'($urandom_range(0, 5)), 28'($urandom)}, {4'($urandom_range(0, 5)), 28'($urandom)});
        mm.drive(2'h0, 32'h0, 32'h0);
        repeat (2) @(negedge i_sys_clk);
    endtask : burst
    task automatic ctl(input logic [4:0] p, input logic [1:0] i);
        @(negedge i_sys_clk);
        {i_remap_set, i_remap_clr, i_nv_set, i_nv_clr, i_full_erase} = p;
        i_nv_idx = i;
        @(negedge i_sys_clk);
        {i_remap_set, i_remap_clr, i_nv_set, i_nv_clr, i_full_erase} = 5'h0;
    endtask : ctl
    task automatic st(input logic [5:0] e);
        chk({28'h0, o_sram_at_zero_select, o_boot_source_select, o_nv_bits}, {28'h0, e});
    endtask : st
    task automatic sysrst;
        @(negedge i_sys_clk);
        i_rstn = 1'b0;
        @(negedge i_sys_clk);
        i_rstn = 1'b1;
        @(negedge i_sys_clk);
    endtask : sysrst
    // results are paired with expectations in request order, master 0 first
    always @(negedge i_sys_clk) begin
        cyc++;
        if (cyc > 1000) begin
            failures++;
            end_of_test();
        end
        for (int m = 0; m < 2; m++) begin
            if (o_m_valid[m] === 1'b1) begin
                if (expq.size() == 0) begin
                    chk({o_m_target[m], o_m_offset[m]}, 34'h3_ffff_ffff);
                end else begin
                    chk({o_m_target[m], o_m_offset[m]}, expq.pop_front());
                end
            end
        end
    end
    initial begin
        {i_rstn, i_por_n, i_remap_set, i_remap_clr, i_nv_set, i_nv_clr, i_full_erase} = 7'h0;
        i_nv_idx = 2'h0;
        remap_m = 1'b0;
        boot_m = 1'b0;
        void'($urandom(32'hde9fd7a2));
        repeat (2) @(negedge i_sys_clk);
        {i_rstn, i_por_n} = 2'h3;
        @(negedge i_sys_clk);
        st(6'h00);
        burst();
        req(32'h0fff_ffff, 32'h1000_0000);
        mm.drive(2'h0, 32'h0, 32'h0);
        ctl(5'b00100, 2'd3);
        st(6'h08);
        burst();
        sysrst();
        boot_m = 1'b1;
        st(6'h18);
        burst();
        ctl(5'b10000, 2'd0);
        remap_m = 1'b1;
        st(6'h38);
        burst();
        ctl(5'b11000, 2'd0);
        st(6'h38);
        ctl(5'b01000, 2'd0);
        remap_m = 1'b0;
        st(6'h18);
        ctl(5'b00100, 2'd0);
        st(6'h19);
        ctl(5'b00010, 2'd0);
        st(6'h18);
        ctl(5'b00111, 2'd3);
        st(6'h10);
        burst();
        ctl(5'b10000, 2'd0);
        sysrst();
        boot_m = 1'b0;
        st(6'h00);
        burst();
        chk(34'(expq.size()), 34'h0);
        end_of_test();
    end
endmodule : tb_boot_memory_remap_decoder
`default_nettype wire
